/* mahpm_regs.sv */
// Station address, group hash table and PHY management registers with an Avalon-MM slave port.
//
// Operation
// (R1) High address register holds bits 47:32.
// (R2) EEPROM bytes 0x05, 0x06 load high register.
// (R3) EEPROM bytes 0x01 to 0x04 load low register.
// (R4) Low register byte 0 goes first on wire.
// (R5) Host address writes allowed only after load.
// (R6) Index top bit picks register, rest bit.
// (R7) Value 0 is low bit 0; 63 high bit 31.
// (R8) Hash bit one accepts, zero rejects group frame.
// (R9) Pass-all bit accepts every group frame.
// (R10) Upper and lower hash halves, both read/write.
// (R11) Software writes PHY address 00001b always.
// (R12) Access bits 10:6 pick the PHY register.
// (R13) Write bit selects PHY write, else read.
// (R14) Software waits busy zero before writing.
// (R15) Software starts access by setting busy.
// (R16) Busy stays set until access completes.
// (R17) Software keeps data steady during PHY write.
// (R18) Read data invalid until busy clears.
// (R19) Data register carries 16-bit PHY value.
// (R20) Hash index from upper CRC-32 bits.
// (R21) Access runs as a clause-22 management frame.
`default_nettype none
`include "mahpm_defs.svh"
module mahpm_regs #(
	parameter logic [7:0] MDC_HALF_CYCLES = 8'(`MAHPM_MDC_HALF_CYC)
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rstn,
	// Avalon-MM slave, byte addressed.
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Station address bytes from the EEPROM controller.
	input wire logic eepromByteValid,
	input wire logic [7:0] eepromByteAddr,
	input wire logic [7:0] eepromByteData,
	input wire logic eepromLoadDone,
	// Receive address filter.
	input wire logic frameAddrValid,
	input wire logic [47:0] frameDestAddr,
	output logic filterValid,
	output logic groupFrame,
	output logic groupAccept,
	output logic stationMatch,
	// PHY management pins.
	output logic mdc,
	input wire logic mdioIn,
	output logic mdioOut,
	output logic mdioOe
);
	// ======================================================================
	// Register state.
	logic [31:0] stationAddressHigh;
	logic [31:0] stationAddressLow;
	logic [31:0] groupHashUpper;
	logic [31:0] groupHashLower;
	logic [15:0] phyMgmtAccess;
	logic [15:0] phyMgmtData;
	logic acceptAllGroupFrames;
	logic addressLoaded;
	logic mgmtStart;
	logic mgmtDone;
	logic [15:0] mgmtReadData;

	// Bus decode.
	logic busAccept;
	logic [2:0] regIndex;
	logic phyAccessBusy;
	logic phyWriteNotRead;

	assign busAccept = (read | write) & ~waitrequest;
	assign regIndex = address[4:2];
	assign phyAccessBusy = phyMgmtAccess[`MAHPM_ACC_BUSY_BIT];
	assign phyWriteNotRead = phyMgmtAccess[`MAHPM_ACC_WRITE_BIT];

	// ======================================================================
	// Merge write data into a register under the byte enables.
	function automatic logic [31:0] mergeBytes(input logic [31:0] oldValue, input logic [31:0] newValue,
		input logic [3:0] enables);
		logic [31:0] result;
		result = oldValue;
		for (int lane = 0; lane < 4; lane++) begin
			if (enables[lane]) begin
				result[lane*8 +: 8] = newValue[lane*8 +: 8];
			end
		end
		return result;
	endfunction

	// Register read mux; unmapped indices read as zero.
	function automatic logic [31:0] readValue(input logic [2:0] idx, input logic [31:0] high,
		input logic [31:0] low, input logic [31:0] hashUp, input logic [31:0] hashLow,
		input logic [15:0] access, input logic [15:0] data, input logic acceptAll, input logic loaded);
		logic [31:0] value;
		value = 32'h00000000;
		unique case (idx)
			`MAHPM_IDX_FILTER_CONTROL: begin
				value[`MAHPM_CTRL_ACCEPT_ALL_BIT] = acceptAll;
				value[`MAHPM_CTRL_LOADED_BIT] = loaded;
			end
			`MAHPM_IDX_STATION_ADDRESS_HIGH: value = {16'h0000, high[15:0]};
			`MAHPM_IDX_STATION_ADDRESS_LOW: value = low;
			`MAHPM_IDX_GROUP_HASH_UPPER: value = hashUp;
			`MAHPM_IDX_GROUP_HASH_LOWER: value = hashLow;
			`MAHPM_IDX_PHY_MGMT_ACCESS: value = {16'h0000, access};
			`MAHPM_IDX_PHY_MGMT_DATA: value = {16'h0000, data};
			default: value = 32'h00000000;
		endcase
		return value;
	endfunction

	// ======================================================================
	// Avalon handshake: every access takes two cycles, waitrequest drops for the answering cycle only.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			waitrequest <= 1'b1;
			readdata <= 32'h00000000;
		end else begin
			waitrequest <= ~((read | write) & waitrequest);
			if (read & waitrequest) begin
				readdata <= readValue(regIndex, stationAddressHigh, stationAddressLow, groupHashUpper,
					groupHashLower, phyMgmtAccess, phyMgmtData, acceptAllGroupFrames, addressLoaded);
			end
		end
	end

	// ======================================================================
	// Initialisation flag; the EEPROM controller raises done even when no programmed EEPROM is found.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			addressLoaded <= 1'b0;
		end else if (eepromLoadDone) begin
			addressLoaded <= 1'b1;
		end
	end

	// Station address: EEPROM bytes before initialisation ends, host writes only afterwards.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			stationAddressHigh <= `MAHPM_RST_STATION_ADDRESS_HIGH;
			stationAddressLow <= `MAHPM_RST_STATION_ADDRESS_LOW;
		end else if (!addressLoaded) begin
			if (eepromByteValid) begin
				unique case (eepromByteAddr)
					`MAHPM_EE_LOW_BYTE0: stationAddressLow[7:0] <= eepromByteData; // R3
					`MAHPM_EE_LOW_BYTE1: stationAddressLow[15:8] <= eepromByteData; // R3
					`MAHPM_EE_LOW_BYTE2: stationAddressLow[23:16] <= eepromByteData; // R3
					`MAHPM_EE_LOW_BYTE3: stationAddressLow[31:24] <= eepromByteData; // R3
					`MAHPM_EE_HIGH_BYTE0: stationAddressHigh[7:0] <= eepromByteData; // R2
					`MAHPM_EE_HIGH_BYTE1: stationAddressHigh[15:8] <= eepromByteData; // R2
					default: ;
				endcase
			end
		end else if (busAccept & write) begin // R5
			if (regIndex == `MAHPM_IDX_STATION_ADDRESS_HIGH) begin
				stationAddressHigh <= mergeBytes(stationAddressHigh, writedata, byteenable) & 32'h0000ffff; // R1
			end
			if (regIndex == `MAHPM_IDX_STATION_ADDRESS_LOW) begin
				stationAddressLow <= mergeBytes(stationAddressLow, writedata, byteenable);
			end
		end
	end

	// ======================================================================
	// Hash table halves and the pass-all control bit.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			groupHashUpper <= `MAHPM_RST_GROUP_HASH_UPPER;
			groupHashLower <= `MAHPM_RST_GROUP_HASH_LOWER;
			acceptAllGroupFrames <= 1'b0;
		end else if (busAccept & write) begin
			if (regIndex == `MAHPM_IDX_GROUP_HASH_UPPER) begin
				groupHashUpper <= mergeBytes(groupHashUpper, writedata, byteenable); // R10
			end
			if (regIndex == `MAHPM_IDX_GROUP_HASH_LOWER) begin
				groupHashLower <= mergeBytes(groupHashLower, writedata, byteenable); // R10
			end
			if (regIndex == `MAHPM_IDX_FILTER_CONTROL && byteenable[0]) begin
				acceptAllGroupFrames <= writedata[`MAHPM_CTRL_ACCEPT_ALL_BIT];
			end
		end
	end

	// ======================================================================
	// Access and data registers. Writes while busy are dropped, so a careless host cannot corrupt
	// an access in flight; the only clear of busy comes from the sequencer finishing.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			phyMgmtAccess <= `MAHPM_RST_PHY_MGMT_ACCESS;
			phyMgmtData <= `MAHPM_RST_PHY_MGMT_DATA;
			mgmtStart <= 1'b0;
		end else begin
			mgmtStart <= 1'b0;
			if (mgmtDone) begin
				phyMgmtAccess[`MAHPM_ACC_BUSY_BIT] <= 1'b0; // R16
				if (!phyWriteNotRead) begin
					phyMgmtData <= mgmtReadData; // R18
				end
			end else if (busAccept & write & ~phyAccessBusy) begin
				if (regIndex == `MAHPM_IDX_PHY_MGMT_ACCESS) begin
					phyMgmtAccess <= 16'(mergeBytes({16'h0000, phyMgmtAccess}, writedata, byteenable))
						& `MAHPM_ACC_WRITABLE_MASK;
					mgmtStart <= byteenable[0] & writedata[`MAHPM_ACC_BUSY_BIT];
				end
				if (regIndex == `MAHPM_IDX_PHY_MGMT_DATA) begin
					phyMgmtData <= 16'(mergeBytes({16'h0000, phyMgmtData}, writedata, byteenable)); // R19
				end
			end
		end
	end

	// ======================================================================
	// Management data input synchroniser.
	logic mdioMeta;
	logic mdioSync;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			mdioMeta <= 1'b0;
			mdioSync <= 1'b0;
		end else begin
			mdioMeta <= mdioIn;
			mdioSync <= mdioMeta;
		end
	end

	// ======================================================================
	// Clause-22 frame sequencer: 32 preamble ones, then start, opcode, PHY address, register,
	// turnaround and 16 data bits. Output changes after MDC falls, input is sampled as MDC rises.
	mahpm_pkg::mahpm_mgmt_state_type mgmtState;
	logic [7:0] halfCount;
	logic [5:0] bitCount;
	logic [63:0] shiftOut;
	logic [31:0] frameWord;
	logic [5:0] next_bitCount;

	assign frameWord = {`MAHPM_MDIO_START,
		phyWriteNotRead ? `MAHPM_MDIO_OP_WRITE : `MAHPM_MDIO_OP_READ, // R13
		phyMgmtAccess[`MAHPM_ACC_PHYADDR_MSB:`MAHPM_ACC_PHYADDR_LSB],
		phyMgmtAccess[`MAHPM_ACC_REGIDX_MSB:`MAHPM_ACC_REGIDX_LSB], // R12
		phyWriteNotRead ? `MAHPM_MDIO_TA_WRITE : `MAHPM_MDIO_TA_READ,
		phyMgmtData}; // R21
	assign next_bitCount = bitCount + 6'h01;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			mgmtState <= mahpm_pkg::MGMT_IDLE;
			halfCount <= 8'h00;
			bitCount <= 6'h00;
			shiftOut <= 64'h0000000000000000;
			mgmtReadData <= 16'h0000;
			mgmtDone <= 1'b0;
			mdc <= 1'b0;
			mdioOut <= 1'b0;
			mdioOe <= 1'b0;
		end else begin
			mgmtDone <= 1'b0;
			unique case (mgmtState)
				mahpm_pkg::MGMT_IDLE: begin
					if (mgmtStart) begin // R15
						mgmtState <= mahpm_pkg::MGMT_SHIFT;
						shiftOut <= {`MAHPM_MDIO_PREAMBLE, frameWord}; // R21
						halfCount <= 8'h00;
						bitCount <= 6'h00;
						mdc <= 1'b0;
						mdioOut <= 1'b1;
						mdioOe <= 1'b1;
					end
				end
				mahpm_pkg::MGMT_SHIFT: begin
					if (halfCount == MDC_HALF_CYCLES - 8'h01) begin
						halfCount <= 8'h00;
						mdc <= ~mdc;
						if (!mdc) begin
							// Rising edge: collect read data bits, most significant first.
							if (!phyWriteNotRead && bitCount >= `MAHPM_MDIO_DATA_START) begin
								mgmtReadData <= {mgmtReadData[14:0], mdioSync};
							end
						end else if (bitCount == `MAHPM_MDIO_LAST_BIT) begin
							mgmtState <= mahpm_pkg::MGMT_FINISH;
							mdioOut <= 1'b0;
							mdioOe <= 1'b0;
						end else begin
							bitCount <= next_bitCount;
							shiftOut <= {shiftOut[62:0], 1'b0};
							mdioOut <= shiftOut[62];
							// On a read the PHY owns the line from the turnaround onward.
							mdioOe <= phyWriteNotRead | (next_bitCount < `MAHPM_MDIO_READ_DRIVE_BITS); // R13
						end
					end else begin
						halfCount <= halfCount + 8'h01;
					end
				end
				mahpm_pkg::MGMT_FINISH: begin
					mgmtState <= mahpm_pkg::MGMT_IDLE;
					mgmtDone <= 1'b1; // R16
				end
			endcase
		end
	end

	// ======================================================================
	// Address filter: hash stage in the leaf, then the accept decision here.
	logic indexValid;
	logic [5:0] hashIndex;
	logic groupStage;
	logic matchStage;
	logic [63:0] hashTable;

	mahpm_hash_index hashUnit (
		.core_clk(core_clk),
		.rstn(rstn),
		.addrValid(frameAddrValid),
		.destAddr(frameDestAddr),
		.indexValid(indexValid),
		.hashIndex(hashIndex)
	);

	// Upper half sits above the lower, so index bit 5 picks the register and bits 4:0 the bit.
	assign hashTable = {groupHashUpper, groupHashLower}; // R6 R7

	// The group bit is the least significant bit of the first wire byte.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			groupStage <= 1'b0;
			matchStage <= 1'b0;
		end else begin
			groupStage <= frameDestAddr[0];
			matchStage <= frameDestAddr == {stationAddressHigh[15:0], stationAddressLow}; // R4
		end
	end

	// Filter verdict, two cycles after the address is offered.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			filterValid <= 1'b0;
			groupFrame <= 1'b0;
			groupAccept <= 1'b0;
			stationMatch <= 1'b0;
		end else begin
			filterValid <= indexValid;
			groupFrame <= groupStage;
			groupAccept <= groupStage & (acceptAllGroupFrames | hashTable[hashIndex]); // R8 R9
			stationMatch <= matchStage;
		end
	end
endmodule
`default_nettype wire

/* mahpm_defs.svh */
// Offsets, field positions, reset values and timing counts of the address, hash and PHY management registers.
`ifndef MAHPM_DEFS_SVH
`define MAHPM_DEFS_SVH

// ==========================================================================
// Register indices (byte address is four times the index).
`define MAHPM_IDX_FILTER_CONTROL 3'h1
`define MAHPM_IDX_STATION_ADDRESS_HIGH 3'h2
`define MAHPM_IDX_STATION_ADDRESS_LOW 3'h3
`define MAHPM_IDX_GROUP_HASH_UPPER 3'h4
`define MAHPM_IDX_GROUP_HASH_LOWER 3'h5
`define MAHPM_IDX_PHY_MGMT_ACCESS 3'h6
`define MAHPM_IDX_PHY_MGMT_DATA 3'h7

// ==========================================================================
// Reset values.
`define MAHPM_RST_STATION_ADDRESS_HIGH 32'h00000fff
`define MAHPM_RST_STATION_ADDRESS_LOW 32'h0fffffff
`define MAHPM_RST_GROUP_HASH_UPPER 32'h00000000
`define MAHPM_RST_GROUP_HASH_LOWER 32'h00000000
`define MAHPM_RST_PHY_MGMT_ACCESS 16'h0000
`define MAHPM_RST_PHY_MGMT_DATA 16'h0000

// ==========================================================================
// Field positions.
`define MAHPM_CTRL_ACCEPT_ALL_BIT 0
`define MAHPM_CTRL_LOADED_BIT 1
`define MAHPM_ACC_BUSY_BIT 0
`define MAHPM_ACC_WRITE_BIT 1
`define MAHPM_ACC_REGIDX_LSB 6
`define MAHPM_ACC_REGIDX_MSB 10
`define MAHPM_ACC_PHYADDR_LSB 11
`define MAHPM_ACC_PHYADDR_MSB 15
`define MAHPM_ACC_WRITABLE_MASK 16'hffc3

// ==========================================================================
// EEPROM byte addresses of the six station address bytes.
`define MAHPM_EE_LOW_BYTE0 8'h01
`define MAHPM_EE_LOW_BYTE1 8'h02
`define MAHPM_EE_LOW_BYTE2 8'h03
`define MAHPM_EE_LOW_BYTE3 8'h04
`define MAHPM_EE_HIGH_BYTE0 8'h05
`define MAHPM_EE_HIGH_BYTE1 8'h06

// ==========================================================================
// Management frame layout and timing.
`define MAHPM_CLK_PERIOD_NS 100
`define MAHPM_MDC_HALF_NS 200
`define MAHPM_MDC_HALF_CYC ((`MAHPM_MDC_HALF_NS + `MAHPM_CLK_PERIOD_NS - 1) / `MAHPM_CLK_PERIOD_NS)
`define MAHPM_MDIO_PREAMBLE 32'hffffffff
`define MAHPM_MDIO_LAST_BIT 6'h3f
`define MAHPM_MDIO_READ_DRIVE_BITS 6'h2e
`define MAHPM_MDIO_DATA_START 6'h30
`define MAHPM_MDIO_START 2'h1
`define MAHPM_MDIO_OP_WRITE 2'h1
`define MAHPM_MDIO_OP_READ 2'h2
`define MAHPM_MDIO_TA_WRITE 2'h2
`define MAHPM_MDIO_TA_READ 2'h0

// ==========================================================================
// Group address hashing.
`define MAHPM_CRC_POLY 32'hedb88320
`define MAHPM_CRC_INIT 32'hffffffff

`endif

/* mahpm_pkg.sv */
// Types shared by the address, hash and PHY management register block.
`default_nettype none
package mahpm_pkg;
	// ======================================================================
	// Management frame sequencer states.
	typedef enum logic [1:0] {
		MGMT_IDLE,
		MGMT_SHIFT,
		MGMT_FINISH
	} mahpm_mgmt_state_type;
endpackage
`default_nettype wire

/* mahpm_hash_index.sv */
// CRC-based six-bit hash index of a destination address.
`default_nettype none
`include "mahpm_defs.svh"
module mahpm_hash_index (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rstn,
	// Destination address in, first wire byte in bits 7:0.
	input wire logic addrValid,
	input wire logic [47:0] destAddr,
	// Hash index out, one cycle later.
	output logic indexValid,
	output logic [5:0] hashIndex
);
	// ======================================================================
	// Reflected CRC-32 over the address, each byte least significant bit first as on the wire.
	function automatic logic [31:0] crcOfAddress(input logic [47:0] addr);
		logic [31:0] crc;
		logic feedback;
		crc = `MAHPM_CRC_INIT;
		for (int i = 0; i < 48; i++) begin
			feedback = crc[0] ^ addr[i];
			crc = {1'b0, crc[31:1]};
			if (feedback) begin
				crc = crc ^ `MAHPM_CRC_POLY;
			end
		end
		return crc;
	endfunction

	logic [31:0] crcValue;
	assign crcValue = crcOfAddress(destAddr);

	// The six top bits of the unreflected CRC are the six low bits here, in reverse order.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			indexValid <= 1'b0;
			hashIndex <= 6'h00;
		end else begin
			indexValid <= addrValid;
			hashIndex <= {crcValue[0], crcValue[1], crcValue[2], crcValue[3], crcValue[4], crcValue[5]}; // R20
		end
	end
endmodule
`default_nettype wire

/* mahpm_regs_props.sv */
// Concurrent checks on the ports of the address, hash and PHY management register block.
`default_nettype none
module mahpm_regs_props #(
	parameter logic [7:0] MDC_HALF_CYCLES = 8'h02
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rstn,
	// Register bus.
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// Receive address filter.
	input wire logic frameAddrValid,
	input wire logic [47:0] frameDestAddr,
	input wire logic filterValid,
	input wire logic groupFrame,
	input wire logic groupAccept,
	// PHY management pins.
	input wire logic mdc,
	input wire logic mdioOut,
	input wire logic mdioOe
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// ======================================================================
	// Helper logic.
	logic mdcPrev;
	logic [7:0] mdcHold;
	// Count how long mdc has held its level, since the frame timing hangs on the high phase.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			mdcPrev <= 1'b0;
			mdcHold <= 8'h00;
		end else begin
			mdcPrev <= mdc;
			mdcHold <= (mdc != mdcPrev) ? 8'h00 : mdcHold + 8'h01;
		end
	end
	// ======================================================================
	// Sequences and assertions.
	sequence busReq;
		(read || write) && waitrequest;
	endsequence
	sequence frameStart;
		$rose(mdioOe);
	endsequence
	bus_answer_a: assert property (busReq |=> !waitrequest)
		else $error("bus request not answered in one cycle");
	wait_single_a: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low for more than one cycle");
	readdata_hold_a: assert property ($changed(readdata) |-> read && !waitrequest)
		else $error("readdata changed outside a read answer");
	filter_latency_a: assert property (frameAddrValid |-> ##2 filterValid)
		else $error("filter result missing two cycles after address");
	filter_cause_a: assert property (filterValid |-> $past(frameAddrValid, 2))
		else $error("filter result without an address");
	group_flag_a: assert property (filterValid |-> groupFrame == $past(frameDestAddr[0], 2))
		else $error("group flag does not follow address bit 0");
	reject_nongroup_a: assert property (filterValid && !groupFrame |-> !groupAccept)
		else $error("individual frame accepted as group frame");
	mdc_high_a: assert property (mdcPrev && !mdc |-> mdcHold == MDC_HALF_CYCLES - 8'h01)
		else $error("mdc high phase has the wrong length");
	mdio_falling_a: assert property (mdioOe && $past(mdioOe) && $changed(mdioOut) |-> $fell(mdc))
		else $error("mdio changed away from mdc falling");
	preamble_ones_a: assert property (frameStart |-> mdioOut [*8])
		else $error("frame does not open with preamble ones");
	frame_seen_c: cover property (frameStart);
endmodule
bind mahpm_regs mahpm_regs_props #(.MDC_HALF_CYCLES(MDC_HALF_CYCLES)) u_props (
	.core_clk(core_clk), .rstn(rstn), .read(read), .write(write), .readdata(readdata),
	.waitrequest(waitrequest), .frameAddrValid(frameAddrValid), .frameDestAddr(frameDestAddr),
	.filterValid(filterValid), .groupFrame(groupFrame), .groupAccept(groupAccept),
	.mdc(mdc), .mdioOut(mdioOut), .mdioOe(mdioOe));
`default_nettype wire

/* mahpm_phy_model.sv */
// Behavioural PHY management slave that answers clause-22 frames on the pins.
`default_nettype none
module mahpm_phy_model (
	// Management pins.
	input wire logic mdc,
	input wire logic mdioOut,
	input wire logic mdioOe,
	output logic mdioIn,
	// Fields of the last frame.
	output logic frameOk,
	output logic [4:0] lastPhyAddr,
	output logic [4:0] lastReg
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [63:0] bits;
	logic [15:0] regs [32];
	int bitCnt;
	// Each register starts with a value that names its index, so a wrong index shows on read.
	initial begin
		mdioIn = 1'b0;
		frameOk = 1'b0;
		lastPhyAddr = 5'h00;
		lastReg = 5'h00;
		bitCnt = 0;
		bits = 64'h0;
		for (int i = 0; i < 32; i++) regs[i] = {8'ha5, 3'h0, 5'(i)};
	end
	// A frame begins when the master starts driving the line.
	always @(posedge mdioOe) bitCnt = 0;
	// Sample on mdc rising, then present the next bit; a released line toggles so stale data never passes.
	always @(posedge mdc) begin
		bits[63 - bitCnt] = mdioOe ? mdioOut : 1'b0;
		if (bitCnt == 63) begin
			frameOk = (bits[63:32] === 32'hffffffff) && (bits[31:30] === 2'b01);
			lastPhyAddr = bits[27:23];
			lastReg = bits[22:18];
			if (bits[29:28] === 2'b01) regs[bits[22:18]] = bits[15:0];
		end
		bitCnt++;
		if (bits[29:28] === 2'b10 && bitCnt >= 48 && bitCnt <= 63) begin
			mdioIn = regs[bits[22:18]][63 - bitCnt];
		end else begin
			mdioIn = ~mdioIn;
		end
	end
endmodule
`default_nettype wire

/* tb_mahpm_regs.sv */
// Self-checking bench for the address, hash and PHY management register block.
`default_nettype none
`include "mahpm_defs.svh"
module tb_mahpm_regs;
	timeunit 1ns;
	timeprecision 1ns;
	// ======================================================================
	// Signals; a management half period of four core cycles, twice the design default.
	localparam logic [7:0] HALF = 8'h04;
	logic core_clk = 1'b0, rstn = 1'b0, read = 1'b0, write = 1'b0;
	logic [4:0] address = 5'h00;
	logic [31:0] writedata = 32'h0, readdata, rd;
	logic [3:0] byteenable = 4'hf;
	logic eepromByteValid = 1'b0, eepromLoadDone = 1'b0, frameAddrValid = 1'b0;
	logic [7:0] eepromByteAddr = 8'h00, eepromByteData = 8'h00;
	logic [47:0] frameDestAddr = 48'h0, a;
	logic waitrequest, filterValid, groupFrame, groupAccept, stationMatch;
	logic mdc, mdioIn, mdioOut, mdioOe, frameOk;
	logic [4:0] lastPhyAddr, lastReg;
	logic [63:0] tbl;
	int errors = 0;
	int check_count = 0;
	always #50 core_clk = ~core_clk;
	mahpm_regs #(.MDC_HALF_CYCLES(HALF)) DUT (.core_clk(core_clk), .rstn(rstn), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .eepromByteValid(eepromByteValid), .eepromByteAddr(eepromByteAddr),
		.eepromByteData(eepromByteData), .eepromLoadDone(eepromLoadDone), .frameAddrValid(frameAddrValid),
		.frameDestAddr(frameDestAddr), .filterValid(filterValid), .groupFrame(groupFrame),
		.groupAccept(groupAccept), .stationMatch(stationMatch), .mdc(mdc), .mdioIn(mdioIn),
		.mdioOut(mdioOut), .mdioOe(mdioOe));
	mahpm_phy_model phy (.mdc(mdc), .mdioOut(mdioOut), .mdioOe(mdioOe), .mdioIn(mdioIn),
		.frameOk(frameOk), .lastPhyAddr(lastPhyAddr), .lastReg(lastReg));
	// ======================================================================
	// Tasks.
	task automatic results();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One Avalon-MM access; the request stands until waitrequest is sampled low.
	task automatic bus(input logic wr, input logic [2:0] ix, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		address <= {ix, 2'b00};
		write <= wr;
		read <= !wr;
		writedata <= d;
		for (n = 0; n < 20; n++) begin
			@(posedge core_clk);
			if (waitrequest === 1'b0) break;
		end
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (n == 20) begin
			errors++;
			results();
		end
	endtask
	task automatic rc(input string what, input logic [2:0] ix, input logic [31:0] exp);
		bus(1'b0, ix, 32'h0);
		check(what, rd, exp);
	endtask
	// Polling busy is slow but is the only completion signal software has.
	task automatic waitIdle();
		int n;
		for (n = 0; n < 400; n++) begin
			bus(1'b0, 3'h6, 32'h0);
			if (rd[0] === 1'b0) break;
		end
		if (n == 400) begin
			errors++;
			results();
		end
	endtask
	// Present one destination address and judge the filter result two cycles on.
	task automatic filt(input logic [47:0] da, input logic acc, input logic match);
		@(posedge core_clk);
		frameAddrValid <= 1'b1;
		frameDestAddr <= da;
		@(posedge core_clk);
		frameAddrValid <= 1'b0;
		@(posedge core_clk);
		@(negedge core_clk);
		check("filter", {28'h0, filterValid, groupFrame, groupAccept, stationMatch},
			{28'h0, 1'b1, da[0], acc, match});
	endtask
	function automatic logic [5:0] hidx(input logic [47:0] d);
		logic [31:0] c;
		logic fb;
		c = `MAHPM_CRC_INIT;
		for (int i = 0; i < 48; i++) begin
			fb = c[0] ^ d[i];
			c = c >> 1;
			if (fb) c = c ^ `MAHPM_CRC_POLY;
		end
		return {c[0], c[1], c[2], c[3], c[4], c[5]};
	endfunction
	// ======================================================================
	// Main sequence.
	initial begin
		repeat (10) @(posedge core_clk);
		rstn <= 1'b1;
		rc("high", 3'h2, 32'h00000fff);
		rc("low", 3'h3, 32'h0fffffff);
		rc("hashUp", 3'h4, 32'h0);
		rc("hashLow", 3'h5, 32'h0);
		rc("access", 3'h6, 32'h0);
		rc("data", 3'h7, 32'h0);
		bus(1'b1, 3'h0, 32'hffffffff);
		rc("unmapped", 3'h0, 32'h0);
		bus(1'b1, 3'h2, 32'h00001234);
		rc("early high", 3'h2, 32'h00000fff);
		// Byte 7 must be ignored; bytes 1 to 6 fill the two address registers.
		for (int i = 1; i <= 7; i++) begin
			@(posedge core_clk);
			eepromByteValid <= 1'b1;
			eepromByteAddr <= 8'(i);
			eepromByteData <= 8'(i) * 8'h11;
		end
		@(posedge core_clk);
		eepromByteValid <= 1'b0;
		eepromLoadDone <= 1'b1;
		rc("loaded low", 3'h3, 32'h44332211);
		rc("loaded high", 3'h2, 32'h00006655);
		filt(48'h665544332211, 1'b0, 1'b1);
		filt(48'h112233445566, 1'b0, 1'b0);
		bus(1'b1, 3'h2, 32'hffffabcd);
		rc("host high", 3'h2, 32'h0000abcd);
		// A single-lane write must leave the other three bytes alone.
		byteenable <= 4'h2;
		bus(1'b1, 3'h3, 32'h0000ee00);
		byteenable <= 4'hf;
		rc("lane low", 3'h3, 32'h4433ee11);
		// One hash bit set accepts; every other bit set rejects.
		for (int i = 0; i < 6; i++) begin
			a = {8'(i) * 8'h25, 40'h005e000001};
			tbl = 64'h1 << hidx(a);
			bus(1'b1, 3'h4, tbl[63:32]);
			bus(1'b1, 3'h5, tbl[31:0]);
			filt(a, 1'b1, 1'b0);
			bus(1'b1, 3'h4, ~tbl[63:32]);
			bus(1'b1, 3'h5, ~tbl[31:0]);
			filt(a, 1'b0, 1'b0);
		end
		rc("hash back", 3'h4, ~tbl[63:32]);
		bus(1'b1, 3'h1, 32'h1);
		rc("control", 3'h1, 32'h3);
		filt(a, 1'b1, 1'b0);
		filt({a[47:1], 1'b0}, 1'b0, 1'b0);
		bus(1'b1, 3'h1, 32'h0);
		// PHY write, then reads of the written and of an untouched register.
		bus(1'b1, 3'h7, 32'h0000beef);
		bus(1'b1, 3'h6, {16'h0, 5'h01, 5'h05, 4'h0, 2'b11});
		rc("busy", 3'h6, {16'h0, 5'h01, 5'h05, 4'h0, 2'b11});
		waitIdle();
		check("phy reg", {27'h0, lastReg}, 32'h5);
		check("phy addr", {27'h0, lastPhyAddr}, 32'h1);
		check("frame", {31'h0, frameOk}, 32'h1);
		bus(1'b1, 3'h6, {16'h0, 5'h01, 5'h05, 4'h0, 2'b01});
		waitIdle();
		rc("read back", 3'h7, 32'h0000beef);
		bus(1'b1, 3'h6, {16'h0, 5'h01, 5'h09, 4'h0, 2'b01});
		waitIdle();
		rc("read reg", 3'h7, 32'h0000a509);
		check("read reg idx", {27'h0, lastReg}, 32'h9);
		results();
	end
endmodule
`default_nettype wire
